//--- src/umlc_top.sv
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - Status bit 6 reads as the inverse of the ring pin.
// - Status bit 2 sets when ring pin goes low to high.
// - Channel interrupt asserts while bit 2 set and modem interrupts enabled.
// - Control bit 1 set drives request-to-send low, active.
// - Reset drives request-to-send high, inactive.
// - Loop mode holds request-to-send inactive whatever control holds.
// - Serial output rests marking, at one, after reset.
// - Each channel takes serial input and drives serial output.
module umlc_top
    import umlc_pkg::*;
#(
    parameter int NCH = UMLC_NCH // Only two channels fit the address map
) (
    input wire logic MCLK, // System clock
    input wire logic RESETN, // Master reset, async, active low
    input wire logic [UMLC_AW-1:0] ADDR, // Register address
    input wire logic [UMLC_DW-1:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [UMLC_DW-1:0] RDATA, // Read data, cycle after strobe
    input wire logic [NCH-1:0] RI_N, // Ring indicate pins, low = ring
    input wire logic [NCH-1:0] SERIAL_RX_IN, // Serial receive pins
    output logic [NCH-1:0] SERIAL_TX_OUT, // Serial transmit pins
    output logic [NCH-1:0] RTS_N, // Request to send, low = ready
    output logic [NCH-1:0] CH_IRQ, // Per-channel modem interrupt
    output logic IRQ // Combined masked event interrupt
);
    localparam int NEVT = 2 * NCH;

    // Decode of a per-channel register, used for reads and writes
    function automatic logic ch_hit(
        input logic [UMLC_AW-1:0] a,
        input int ch,
        input logic [2:0] r
    );
        logic ch_ok;
        ch_ok = (a[ADDR_CH_BIT] == ch[0]);
        return !a[ADDR_GLOBAL_BIT] && ch_ok && (a[ADDR_REG_MSB:0] == r);
    endfunction

    logic [UMLC_DW-1:0] rdata_q, rdata_d;
    logic [NEVT-1:0] int_stat_q, int_stat_d;
    logic [NEVT-1:0] int_mask_q, int_mask_d;
    logic [NEVT-1:0] evt_set;
    logic [NEVT-1:0] stat_clr;
    logic irq_q;
    logic wr_stat, wr_mask, rd_stat, rd_mask;
    logic [NCH-1:0] mcr_rts_q, mcr_loop_q, ier_ms_q, txl_q;
    logic [NCH-1:0] ch_sel_rd;
    logic [UMLC_DW-1:0] ch_rd_word [NCH];
    logic [UMLC_DW-1:0] ch_rd_or;
    logic [UMLC_DW-1:0] glb_rd_word;
    logic [NCH-1:0] sout_w, rts_n_w, irq_w;

    umlc_ch_if cbus [NCH] ();

    // Global register decode
    assign wr_stat = WR && (ADDR == ADDR_INT_STAT);
    assign wr_mask = WR && (ADDR == ADDR_INT_MASK);
    assign rd_stat = RD && (ADDR == ADDR_INT_STAT);
    assign rd_mask = RD && (ADDR == ADDR_INT_MASK);

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic wr_mcr, wr_ier, wr_txl;
            logic sel_mcr, sel_msr, sel_ier, sel_txl, sel_rxl;
            logic [UMLC_DW-1:0] mcr_word, msr_word, ier_word;
            logic [UMLC_DW-1:0] txl_word, rxl_word;

            // Register selects for this channel
            assign sel_mcr = ch_hit(ADDR, c, REG_MCR);
            assign sel_msr = ch_hit(ADDR, c, REG_MSR);
            assign sel_ier = ch_hit(ADDR, c, REG_IER);
            assign sel_txl = ch_hit(ADDR, c, REG_TXL);
            assign sel_rxl = ch_hit(ADDR, c, REG_RXL);
            assign wr_mcr = WR && sel_mcr;
            assign wr_ier = WR && sel_ier;
            assign wr_txl = WR && sel_txl;

            // Control registers; unlisted bits are not stored
            always_ff @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    mcr_rts_q[c] <= MCR_RTS_RST;
                    mcr_loop_q[c] <= MCR_LOOP_RST;
                    ier_ms_q[c] <= IER_MS_RST;
                    txl_q[c] <= TXL_RST;
                end else begin
                    if (wr_mcr) begin
                        mcr_rts_q[c] <= WDATA[MCR_RTS_BIT];
                        mcr_loop_q[c] <= WDATA[MCR_LOOP_BIT];
                    end
                    if (wr_ier) begin
                        ier_ms_q[c] <= WDATA[IER_MS_BIT];
                    end
                    if (wr_txl) begin
                        txl_q[c] <= WDATA[TXL_BIT];
                    end
                end
            end

            // Controls to the channel; a status read clears the trailing-edge flag
            assign cbus[c].mcr_rts = mcr_rts_q[c];
            assign cbus[c].mcr_loop = mcr_loop_q[c];
            assign cbus[c].tx_level = txl_q[c];
            assign cbus[c].ms_int_en = ier_ms_q[c];
            assign cbus[c].msr_rd = RD && sel_msr;

            // Read words, bits outside the fields read zero
            always_comb begin
                mcr_word = RD_ZERO;
                mcr_word[MCR_RTS_BIT] = mcr_rts_q[c];
                mcr_word[MCR_LOOP_BIT] = mcr_loop_q[c];
            end
            always_comb begin
                msr_word = RD_ZERO;
                msr_word[MSR_RI_BIT] = cbus[c].ri_act;
                msr_word[MSR_RING_TRAILING_EDGE_FLAG_BIT] = cbus[c].ring_trailing_edge_flag;
            end
            always_comb begin
                ier_word = RD_ZERO;
                ier_word[IER_MS_BIT] = ier_ms_q[c];
            end
            always_comb begin
                txl_word = RD_ZERO;
                txl_word[TXL_BIT] = txl_q[c];
            end
            always_comb begin
                rxl_word = RD_ZERO;
                rxl_word[RXL_BIT] = cbus[c].rx_level;
            end

            // Channel read selection
            assign ch_sel_rd[c] = sel_mcr | sel_msr | sel_ier | sel_txl | sel_rxl;
            assign ch_rd_word[c] = sel_mcr ? mcr_word :
                                   sel_msr ? msr_word :
                                   sel_ier ? ier_word :
                                   sel_txl ? txl_word :
                                   sel_rxl ? rxl_word : RD_ZERO;

            // Events into the sticky status register
            assign evt_set[INT_RING_LSB + c] = cbus[c].ring_evt;
            assign evt_set[INT_RXS_LSB + c] = cbus[c].rx_fall;

            // Pin drivers come from channel flip-flops
            assign sout_w[c] = cbus[c].sout;
            assign rts_n_w[c] = cbus[c].rts_n;
            assign irq_w[c] = cbus[c].irq;

            umlc_chan u_chan (
                .clk(MCLK),
                .rst_n(RESETN),
                .ri_n_pin(RI_N[c]),
                .rx_pin(SERIAL_RX_IN[c]),
                .cb(cbus[c])
            );
        end
    endgenerate

    // OR-merge of channel words; only one channel is selected at a time
    always_comb begin
        ch_rd_or = RD_ZERO;
        for (int i = 0; i < NCH; i++) begin
            ch_rd_or = ch_rd_or | ch_rd_word[i];
        end
    end

    // Global read words
    assign glb_rd_word = rd_stat ? UMLC_DW'(int_stat_q) :
                         rd_mask ? UMLC_DW'(int_mask_q) : RD_ZERO;

    // Read data register; unmapped addresses answer zero
    assign rdata_d = !RD ? RD_ZERO :
                     (|ch_sel_rd) ? ch_rd_or : glb_rd_word;

    // Write-one-to-clear, but an event in the same cycle wins
    assign stat_clr = wr_stat ? WDATA[NEVT-1:0] : '0;
    assign int_stat_d = evt_set | (int_stat_q & ~stat_clr);
    assign int_mask_d = wr_mask ? WDATA[NEVT-1:0] : int_mask_q;

    // Status, mask and read data flip-flops
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            int_stat_q <= INT_RST;
            int_mask_q <= INT_RST;
            rdata_q <= RD_ZERO;
        end else begin
            int_stat_q <= int_stat_d;
            int_mask_q <= int_mask_d;
            rdata_q <= rdata_d;
        end
    end

    // Level interrupt follows the masked status one cycle later
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    assign RDATA = rdata_q;
    assign IRQ = irq_q;
    assign SERIAL_TX_OUT = sout_w;
    assign RTS_N = rts_n_w;
    assign CH_IRQ = irq_w;
endmodule

//--- src/umlc_pkg.sv
package umlc_pkg;
    // Channel count and register bus widths
    localparam int UMLC_NCH = 2;
    localparam int UMLC_AW = 5;
    localparam int UMLC_DW = 8;
    localparam int UMLC_NEVT = 2 * UMLC_NCH;

    // Address fields: global bit, channel bit, per-channel register field
    localparam int ADDR_GLOBAL_BIT = 4;
    localparam int ADDR_CH_BIT = 3;
    localparam int ADDR_REG_MSB = 2;

    // Per-channel register offsets
    localparam logic [2:0] REG_MCR = 3'h0;
    localparam logic [2:0] REG_MSR = 3'h1;
    localparam logic [2:0] REG_IER = 3'h2;
    localparam logic [2:0] REG_TXL = 3'h3;
    localparam logic [2:0] REG_RXL = 3'h4;

    // Global register addresses
    localparam logic [4:0] ADDR_INT_STAT = 5'h10;
    localparam logic [4:0] ADDR_INT_MASK = 5'h11;

    // Field positions
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_LOOP_BIT = 4;
    localparam int MSR_RING_TRAILING_EDGE_FLAG_BIT = 2;
    localparam int MSR_RI_BIT = 6;
    localparam int IER_MS_BIT = 3;
    localparam int TXL_BIT = 0;
    localparam int RXL_BIT = 0;
    localparam int INT_RING_LSB = 0;
    localparam int INT_RXS_LSB = UMLC_NCH;

    // Reset values
    localparam logic MCR_RTS_RST = 1'b0;
    localparam logic MCR_LOOP_RST = 1'b0;
    localparam logic IER_MS_RST = 1'b0;
    localparam logic TXL_RST = 1'b1;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic [UMLC_NEVT-1:0] INT_RST = '0;
endpackage

//--- src/umlc_ch_if.sv
`timescale 1ns/1ps
interface umlc_ch_if;
    // Controls from the register file
    logic mcr_rts;
    logic mcr_loop;
    logic tx_level;
    logic msr_rd;
    logic ms_int_en;
    // State back from the channel
    logic ri_act;
    logic ring_trailing_edge_flag;
    logic rx_level;
    logic rx_fall;
    logic ring_evt;
    logic rts_n;
    logic sout;
    logic irq;

    modport ctl (
        output mcr_rts, mcr_loop, tx_level, msr_rd, ms_int_en,
        input ri_act, ring_trailing_edge_flag, rx_level, rx_fall, ring_evt, rts_n, sout, irq
    );
    modport chan (
        input mcr_rts, mcr_loop, tx_level, msr_rd, ms_int_en,
        output ri_act, ring_trailing_edge_flag, rx_level, rx_fall, ring_evt, rts_n, sout, irq
    );
endinterface

//--- src/umlc_chan.sv
`timescale 1ns/1ps
module umlc_chan
    import umlc_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Master reset, active low
    input wire logic ri_n_pin, // Ring indicate pin
    input wire logic rx_pin, // Serial receive pin
    umlc_ch_if.chan cb // Register side
);
    logic ri_s1_q, ri_s2_q, ri_s3_q, ri_lvl_q, ri_lvl_d;
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q, rx_lvl_d;
    logic ring_trailing_edge_flag_q, ring_trailing_edge_flag_d, ring_evt_q;
    logic rx_seen_q, rx_seen_d, rx_fall_q;
    logic rts_n_q, sout_q, irq_q;
    logic ring_rise;

    // A pin level counts only once stages two and three agree
    assign ri_lvl_d = (ri_s2_q == ri_s3_q) ? ri_s3_q : ri_lvl_q;
    assign rx_lvl_d = (rx_s2_q == rx_s3_q) ? rx_s3_q : rx_lvl_q;
    // Ring ends when the pin returns high
    assign ring_rise = ri_lvl_d & ~ri_lvl_q;
    // Set wins over the clear by a status read
    assign ring_trailing_edge_flag_d = ring_rise | (ring_trailing_edge_flag_q & ~cb.msr_rd);
    // Loop mode feeds the transmit level back internally
    assign rx_seen_d = cb.mcr_loop ? cb.tx_level : rx_lvl_q;

    // Pin synchronisers, idle lines reset high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ri_s1_q <= LINE_IDLE;
            ri_s2_q <= LINE_IDLE;
            ri_s3_q <= LINE_IDLE;
            ri_lvl_q <= LINE_IDLE;
            rx_s1_q <= LINE_IDLE;
            rx_s2_q <= LINE_IDLE;
            rx_s3_q <= LINE_IDLE;
            rx_lvl_q <= LINE_IDLE;
        end else begin
            ri_s1_q <= ri_n_pin;
            ri_s2_q <= ri_s1_q;
            ri_s3_q <= ri_s2_q;
            ri_lvl_q <= ri_lvl_d;
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            rx_lvl_q <= rx_lvl_d;
        end
    end

    // Flags and pin drivers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_trailing_edge_flag_q <= 1'b0;
            ring_evt_q <= 1'b0;
            rx_seen_q <= LINE_IDLE;
            rx_fall_q <= 1'b0;
            rts_n_q <= LINE_IDLE;
            sout_q <= LINE_IDLE;
            irq_q <= 1'b0;
        end else begin
            ring_trailing_edge_flag_q <= ring_trailing_edge_flag_d;
            ring_evt_q <= ring_rise;
            rx_seen_q <= rx_seen_d;
            rx_fall_q <= rx_seen_q & ~rx_seen_d;
            rts_n_q <= cb.mcr_loop | ~cb.mcr_rts;
            sout_q <= cb.mcr_loop | cb.tx_level;
            irq_q <= ring_trailing_edge_flag_d & cb.ms_int_en;
        end
    end

    assign cb.ri_act = ~ri_lvl_q;
    assign cb.ring_trailing_edge_flag = ring_trailing_edge_flag_q;
    assign cb.rx_level = rx_seen_q;
    assign cb.rx_fall = rx_fall_q;
    assign cb.ring_evt = ring_evt_q;
    assign cb.rts_n = rts_n_q;
    assign cb.sout = sout_q;
    assign cb.irq = irq_q;
endmodule

//--- bench/umlc_modem.sv
`timescale 1ns/1ps
// Behavioural modem: ring and serial levels per channel
module umlc_modem (
    input wire logic clk, // Bench clock
    input wire logic [1:0] ring, // Ring present per channel
    input wire logic [1:0] line, // Serial level to send
    output logic [1:0] ri_n, // Ring pins, low while ringing
    output logic [1:0] rx // Serial data pins
);
    // Pins move one edge after the command, like a remote device; one driver per pin
    always @(posedge clk) begin
        ri_n <= ~ring;
        rx <= line;
    end
endmodule

//--- bench/umlc_checker.sv
`timescale 1ns/1ps
module umlc_checker
    import umlc_pkg::*;
#(
    parameter int NCH = UMLC_NCH // Channel count
) (
    input wire logic MCLK, // System clock
    input wire logic RESETN, // Master reset
    input wire logic [UMLC_AW-1:0] ADDR, // Register address
    input wire logic [UMLC_DW-1:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic [UMLC_DW-1:0] RDATA, // Read data
    input wire logic [NCH-1:0] RI_N, // Ring pins
    input wire logic [NCH-1:0] SERIAL_RX_IN, // Serial inputs
    input wire logic [NCH-1:0] SERIAL_TX_OUT, // Serial outputs
    input wire logic [NCH-1:0] RTS_N, // Request to send
    input wire logic [NCH-1:0] CH_IRQ, // Channel interrupts
    input wire logic IRQ // Combined interrupt
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    // Channel 0 decodes only; channel 1 is the same logic
    wire logic msr0_rd = RD && ADDR == {2'b00, REG_MSR};
    wire logic mcr0_wr = WR && ADDR == {2'b00, REG_MCR};
    wire logic txl0_wr = WR && ADDR == {2'b00, REG_TXL};
    wire logic ier0_wr = WR && ADDR == {2'b00, REG_IER};
    wire logic mask_wr = WR && ADDR == ADDR_INT_MASK;
    logic ri_q;
    logic [2:0] st_q;
    logic lp_q;
    logic ie_q;
    logic [3:0] mk_q;

    // Shadow state; stability count guards the ring filter latency
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ri_q <= 1'b1;
            st_q <= 3'h0;
            lp_q <= 1'b0;
            ie_q <= 1'b0;
            mk_q <= 4'h0;
        end else begin
            ri_q <= RI_N[0];
            st_q <= (RI_N[0] != ri_q) ? 3'h0 : ((st_q == 3'h7) ? st_q : st_q + 3'h1);
            if (mcr0_wr) lp_q <= WDATA[MCR_LOOP_BIT];
            if (ier0_wr) ie_q <= WDATA[IER_MS_BIT];
            if (mask_wr) mk_q <= WDATA[3:0];
        end
    end

    rts_reset_a: assert property ($rose(RESETN) |-> RTS_N == '1)
        else $error("request to send not idle after reset");
    tx_reset_a: assert property ($rose(RESETN) |-> SERIAL_TX_OUT == '1)
        else $error("serial output not marking after reset");
    ri_level_a: assert property (msr0_rd && st_q >= 3'h5 |=> RDATA[MSR_RI_BIT] == !$past(RI_N[0]))
        else $error("ring status bit not inverse of pin");
    rts_drive_a: assert property (mcr0_wr ##2 1'b1 |->
        RTS_N[0] == !($past(WDATA[MCR_RTS_BIT], 2) && !$past(WDATA[MCR_LOOP_BIT], 2)))
        else $error("request to send wrong after control write");
    tx_level_a: assert property (txl0_wr ##2 1'b1 |->
        SERIAL_TX_OUT[0] == ($past(WDATA[0], 2) || $past(lp_q)))
        else $error("serial output level wrong");
    ring_irq_a: assert property (RI_N[0] && !ri_q && st_q >= 3'h4 && ie_q |-> ##[2:5] CH_IRQ[0])
        else $error("ring trailing edge raised no interrupt");
    // Both reads on a settled pin, so no late trailing edge can re-set the flag in between
    read_clear_a: assert property ((msr0_rd && st_q >= 3'h5) ##[1:4]
        (msr0_rd && st_q >= 3'h6) |=> !RDATA[MSR_RING_TRAILING_EDGE_FLAG_BIT])
        else $error("trailing edge flag survived a read");
    irq_mask_a: assert property ($past(mk_q) == 4'h0 |-> !IRQ)
        else $error("masked event raised interrupt");

    ring_irq_c: cover property (CH_IRQ[0] && IRQ);
    loop_c: cover property (lp_q && RTS_N[0]);
    reread_c: cover property (msr0_rd ##2 msr0_rd);
endmodule

bind umlc_top umlc_checker #(.NCH(NCH)) chk (.MCLK(MCLK), .RESETN(RESETN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RI_N(RI_N), .SERIAL_RX_IN(SERIAL_RX_IN),
    .SERIAL_TX_OUT(SERIAL_TX_OUT), .RTS_N(RTS_N), .CH_IRQ(CH_IRQ), .IRQ(IRQ));

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    import umlc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [UMLC_AW-1:0] addr = '0;
    logic [UMLC_DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] ring = 2'h0;
    logic [1:0] line = 2'h3;
    logic [UMLC_DW-1:0] rdata, d, t, v;
    logic [1:0] ri_n, rx, tx, rts_n, ch_irq;
    logic irq;
    int fails = 0;
    int checked = 0;
    int cyc = 0;

    umlc_top dut (.MCLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RI_N(ri_n), .SERIAL_RX_IN(rx), .SERIAL_TX_OUT(tx), .RTS_N(rts_n),
        .CH_IRQ(ch_irq), .IRQ(irq));
    umlc_modem peer (.clk(clk), .ring(ring), .line(line), .ri_n(ri_n), .rx(rx));

    initial begin
        forever #5 clk = ~clk;
    end

    // Loop mode picks the internal value over the pin value
    function automatic logic pick(input logic [7:0] m, input logic a, input logic b);
        return m[MCR_LOOP_BIT] ? a : b;
    endfunction

    function automatic logic [4:0] creg(input int c, input logic [2:0] r);
        return {1'b0, c[0], r};
    endfunction

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] dv);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dv;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] q);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic close_out();
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        int c;
        logic en;
        void'($urandom(41910));
        repeat (20) @(posedge clk);
        `CHK(rts_n, 2'h3)
        `CHK(tx, 2'h3)
        rst_n <= 1'b1;
        // Random control and line levels; first passes set rts and loop together
        for (int i = 0; i < 12; i++) begin
            c = i % 2;
            d = (i < 2) ? 8'h12 : 8'($urandom);
            t = 8'($urandom);
            @(posedge clk);
            line <= 2'($urandom);
            wr_reg(creg(c, REG_MCR), d);
            wr_reg(creg(c, REG_TXL), t);
            settle(2);
            `CHK(rts_n[c], !(d[MCR_RTS_BIT] && !d[MCR_LOOP_BIT]))
            `CHK(tx[c], pick(d, 1'b1, t[0]))
            rd_reg(creg(c, REG_RXL), v);
            `CHK(v[0], pick(d, t[0], line[c]))
        end
        rd_reg(5'h1f, v);
        `CHK(v, 8'h00)
        wr_reg(creg(0, REG_MCR), 8'h00);
        wr_reg(creg(1, REG_MCR), 8'h00);
        // Ring on each channel, with interrupts enabled then disabled
        for (int p = 0; p < 4; p++) begin
            c = p % 2;
            en = (p < 2);
            wr_reg(creg(c, REG_IER), en ? 8'h08 : 8'h00);
            wr_reg(ADDR_INT_MASK, en ? 8'h0f : 8'h00);
            wr_reg(ADDR_INT_STAT, 8'hff);
            rd_reg(creg(c, REG_MSR), v);
            @(posedge clk);
            ring[c] <= 1'b1;
            settle(8);
            rd_reg(creg(c, REG_MSR), v);
            `CHK(v[MSR_RI_BIT], 1'b1)
            `CHK(v[MSR_RING_TRAILING_EDGE_FLAG_BIT], 1'b0)
            @(posedge clk);
            ring[c] <= 1'b0;
            settle(8);
            `CHK(ch_irq[c], en)
            `CHK(irq, en)
            rd_reg(creg(c, REG_MSR), v);
            `CHK(v[MSR_RING_TRAILING_EDGE_FLAG_BIT], 1'b1)
            `CHK(v[MSR_RI_BIT], 1'b0)
            rd_reg(creg(c, REG_MSR), v);
            `CHK(v[MSR_RING_TRAILING_EDGE_FLAG_BIT], 1'b0)
            `CHK(ch_irq[c], 1'b0)
            rd_reg(ADDR_INT_STAT, v);
            `CHK(v[1:0], 2'(1 << c))
        end
        // Reset in mid-run with request to send active
        wr_reg(creg(0, REG_MCR), 8'h02);
        settle(2);
        `CHK(rts_n[0], 1'b0)
        @(posedge clk);
        rst_n <= 1'b0;
        settle(2);
        `CHK(rts_n, 2'h3)
        `CHK(tx, 2'h3)
        // Second release: control state must come back at its reset values
        @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(creg(0, REG_MCR), v);
        `CHK(v, 8'h00)
        rd_reg(creg(0, REG_TXL), v);
        `CHK(v[TXL_BIT], TXL_RST)
        `CHK(rts_n, 2'h3)
        `CHK(tx, 2'h3)
        close_out();
    end
endmodule
